// ---- src/fdsm_pkg.sv ----
// Package for the fan duty and speed monitor: configuration and status bit
// positions, duty tables, timing constants and the carrier structs.
// Assumes a single 100 MHz clock and a synchronous active-high reset.
// Operation
// - Duty comes from thermal input when select bit is 0, else register
// - Unconnected thermal input under analog control gives 39.33% duty
// - Duty source select may change any time, takes effect directly
// - Thermal input 1.62 V to 2.6 V maps to 30% to 100% rising
// - Thermal input below range is clamped to 30% duty
// - Input above 2.6 V sets overheat flag and optionally alert low
// - Four-bit duty register decodes linearly from 30% to 100%
// - Power-up and shutdown exit force full duty, then selected source
// - Drive stops only while the power down bit is set
// - Drive keeps pulsing even after a stalled fan is detected
// - Only comparator-qualified sense pulses count toward speed
// - Pulses per revolution field scales the speed, default two
// - Speed held in nine-bit read-only register, step 25 FAN_SPEED_VALUE
// - Fine step bit selects 25 FAN_SPEED_VALUE nine-bit or 50 FAN_SPEED_VALUE eight-bit
// - Speed beyond 12775 FAN_SPEED_VALUE sets the counter overflow flag
// - Overflow flag clears after 2.4 s continuously below maximum
// - Forced full duty lasts one second, then source from config
package fdsm_pkg;
    localparam int CLK_HZ = 100_000_000;
    // Configuration bit positions
    localparam int CFG_PDN_BIT = 0;
    localparam int CFG_PPR_LO = 1;
    localparam int CFG_SRC_BIT = 5;
    localparam int CFG_FINE_BIT = 6;
    localparam logic [7:0] CFG_RESET = 8'h02;
    // Status bit positions
    localparam int STS_OVF_BIT = 3;
    localparam int STS_HOT_BIT = 5;
    // Duty in 1/256 units of a PWM period; 30% and 100% end points
    localparam int DUTY_W = 8;
    localparam logic [8:0] DUTY_MIN = 9'h04D;
    localparam logic [8:0] DUTY_FULL = 9'h100;
    localparam logic [8:0] DUTY_STEP_X3 = 9'h024;
    localparam logic [3:0] DUTY_OPEN_CODE = 4'h2;
    // Thermal code: 8-bit digitised input, end points of the control span
    localparam logic [7:0] VIN_LO = 8'h53;
    localparam logic [7:0] VIN_HI = 8'h85;
    // PWM period in clocks
    localparam int PWM_CLKS = 256;
    // Timing, in milliseconds
    localparam int START_MS = 1000;
    localparam int OVF_MS = 2400;
    localparam int GATE_MS = 1000;
    localparam longint START_CYC = longint'(START_MS) * CLK_HZ / 1000;
    localparam longint OVF_CYC = longint'(OVF_MS) * CLK_HZ / 1000;
    localparam longint GATE_CYC = longint'(GATE_MS) * CLK_HZ / 1000;
    // Speed scale: 25 FAN_SPEED_VALUE per lsb, 9-bit maximum reading
    localparam int RPM_LSB = 25;
    localparam logic [8:0] SPD_MAX = 9'h1FF;
    localparam int SEC_PER_MIN = 60;

    typedef struct packed {
        logic power_down_request;
        logic duty_source_select;
        logic fine_rpm_step_select;
        logic [1:0] pulses_per_rev_select;
    } fdsm_cfg_s;

    typedef struct packed {
        logic overheat_flag;
        logic speed_count_overflow;
    } fdsm_sts_s;
endpackage

// ---- src/fdsm_pwm.sv ----
// PWM generator: period counter compared against a duty in 1/256 units.
// Assumes the duty input is stable or changes only between periods.
`timescale 1ns/1ns
module fdsm_pwm #(
    parameter int PERIOD = 256
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Control
    input wire logic run,
    input wire logic [8:0] duty,
    // Output
    output logic pwm_q
);
    import fdsm_pkg::*;
    logic [8:0] cnt_q;
    logic [8:0] duty_q;
    wire wrap = (cnt_q == 9'(PERIOD - 1));
    wire on_d = run && (cnt_q < duty_q);

    // Duty latched at period wrap to avoid runt pulses
    always_ff @(posedge mclk) begin
        if (sys_rst || !run) begin
            cnt_q <= 9'h000;
            duty_q <= DUTY_FULL;
            pwm_q <= 1'b0;
        end else begin
            cnt_q <= wrap ? 9'h000 : cnt_q + 9'h001;
            if (wrap) begin
                duty_q <= duty;
            end
            pwm_q <= on_d;
        end
    end
endmodule

// ---- src/fdsm_sync.sv ----
// Three-stage synchroniser; output changes once stages two and three agree.
// Assumes the input is asynchronous to mclk.
`timescale 1ns/1ns
module fdsm_sync (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Signals
    input wire logic din,
    output logic dout_q
);
    logic s1_q;
    logic s2_q;
    logic s3_q;

    // Stage one feeds only stage two
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            dout_q <= 1'b0;
        end else begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                dout_q <= s3_q;
            end
        end
    end
endmodule

// ---- src/fdsm_top.sv ----
// Fan duty and speed monitor core: duty source select, start-up kick,
// shutdown, overheat flag and sense pulse speed measurement.
// Assumes the register slave, digitiser and comparator sit outside.
`timescale 1ns/1ns
module fdsm_top #(
    parameter longint START_CYCLES = fdsm_pkg::START_CYC,
    parameter longint OVF_CYCLES = fdsm_pkg::OVF_CYC,
    parameter longint GATE_CYCLES = fdsm_pkg::GATE_CYC,
    parameter bit HOT_ALERT = 1'b1
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Configuration and duty register, from the register slave
    input wire logic [7:0] cfg_wdata,
    input wire logic cfg_we,
    input wire logic [3:0] duty_wdata,
    input wire logic duty_we,
    // Analog front end
    input wire logic [7:0] thermal_voltage_in,
    input wire logic thermal_open,
    input wire logic sense_pulse,
    // Fan drive and alert
    output logic fan_drive_out,
    output logic alert_n,
    // Readback
    output fdsm_pkg::fdsm_cfg_s cfg_q,
    output logic [3:0] fan_duty_setting_q,
    output logic [8:0] fan_speed_reading,
    output fdsm_pkg::fdsm_sts_s sts_q
);
    import fdsm_pkg::*;

    logic [8:0] fan_speed_value_q;
    logic [31:0] start_cnt_q;
    logic kick_q;
    logic pdn_prev_q;
    logic [31:0] gate_cnt_q;
    logic [15:0] pulse_cnt_q;
    logic [31:0] below_cnt_q;
    logic ovf_q;
    logic hot_q;
    logic sense_s;
    logic sense_prev_q;

    // Configuration, duty register; written any time
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            cfg_q.power_down_request <= CFG_RESET[CFG_PDN_BIT];
            cfg_q.duty_source_select <= CFG_RESET[CFG_SRC_BIT];
            cfg_q.fine_rpm_step_select <= CFG_RESET[CFG_FINE_BIT];
            cfg_q.pulses_per_rev_select <= CFG_RESET[CFG_PPR_LO +: 2];
            fan_duty_setting_q <= 4'h0;
        end else begin
            if (cfg_we) begin
                cfg_q.power_down_request <= cfg_wdata[CFG_PDN_BIT];
                cfg_q.duty_source_select <= cfg_wdata[CFG_SRC_BIT];
                cfg_q.fine_rpm_step_select <= cfg_wdata[CFG_FINE_BIT];
                cfg_q.pulses_per_rev_select <= cfg_wdata[CFG_PPR_LO +: 2];
            end
            if (duty_we) begin
                fan_duty_setting_q <= duty_wdata;
            end
        end
    end

    // Duty decode: 30% plus 4.67% steps, code 15 lands on full
    // linear decode
    function automatic logic [8:0] code_duty(input logic [3:0] c);
        logic [8:0] d;
        d = DUTY_MIN + 9'((13'(c) * 13'(DUTY_STEP_X3)) / 13'h3);
        code_duty = (c == 4'hF) ? DUTY_FULL : d;
        return code_duty;
    endfunction

    wire vin_low = thermal_voltage_in <= VIN_LO;
    wire vin_high = thermal_voltage_in >= VIN_HI;
    wire [15:0] vin_span = 16'(thermal_voltage_in - VIN_LO)
        * 16'(DUTY_FULL - DUTY_MIN);
    wire [8:0] vin_duty = vin_low ? DUTY_MIN : vin_high ? DUTY_FULL :
        9'(DUTY_MIN + 9'(vin_span / 16'(VIN_HI - VIN_LO)));

    wire [8:0] analog_duty = thermal_open ? code_duty(DUTY_OPEN_CODE)
        : vin_duty;
    wire [8:0] sel_duty = cfg_q.duty_source_select
        ? code_duty(fan_duty_setting_q) : analog_duty;
    wire [8:0] drive_duty = kick_q ? DUTY_FULL : sel_duty;
    wire run = !cfg_q.power_down_request;

    // Start-up kick: restarts on reset and on leaving power down
    // one second kick
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            start_cnt_q <= 32'h0;
            kick_q <= 1'b1;
            pdn_prev_q <= 1'b0;
        end else begin
            pdn_prev_q <= cfg_q.power_down_request;
            if (!run || (pdn_prev_q && run)) begin
                start_cnt_q <= 32'h0;
                kick_q <= 1'b1;
            end else if (kick_q) begin
                if (start_cnt_q == 32'(START_CYCLES - 1)) begin
                    kick_q <= 1'b0;
                end
                start_cnt_q <= start_cnt_q + 32'h1;
            end
        end
    end

    fdsm_pwm #(
        .PERIOD(PWM_CLKS)
    ) u_pwm (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .run(run),
        .duty(drive_duty),
        .pwm_q(fan_drive_out)
    );

    fdsm_sync u_sense_sync (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .din(sense_pulse),
        .dout_q(sense_s)
    );
    wire sense_rise = sense_s && !sense_prev_q;

    // Speed: pulses per gate times 60 / (ppr * 25)
    // ppr scaling
    wire [31:0] rpm_raw = (32'(pulse_cnt_q) * 32'(SEC_PER_MIN))
        >> cfg_q.pulses_per_rev_select;
    wire [31:0] rpm_lsb = rpm_raw / 32'(RPM_LSB);
    wire over = rpm_lsb > 32'(SPD_MAX);
    wire gate_end = gate_cnt_q == 32'(GATE_CYCLES - 1);

    // Gate counter, pulse count and speed register; cleared in power down
    // nine-bit 25 FAN_SPEED_VALUE reading
    always_ff @(posedge mclk) begin
        if (sys_rst || !run) begin
            gate_cnt_q <= 32'h0;
            pulse_cnt_q <= 16'h0;
            sense_prev_q <= 1'b0;
            fan_speed_value_q <= 9'h000;
        end else begin
            sense_prev_q <= sense_s;
            gate_cnt_q <= gate_end ? 32'h0 : gate_cnt_q + 32'h1;
            if (gate_end) begin
                pulse_cnt_q <= 16'(sense_rise);
                fan_speed_value_q <= over ? SPD_MAX : rpm_lsb[8:0];
            end else if (sense_rise && pulse_cnt_q != 16'hFFFF) begin
                pulse_cnt_q <= pulse_cnt_q + 16'h1;
            end
        end
    end

    assign fan_speed_reading = cfg_q.fine_rpm_step_select ? fan_speed_value_q
        : {1'b0, fan_speed_value_q[8:1]};

    // Overflow sets on a gate over range, clears after 2.4 s below
    // overflow set
    always_ff @(posedge mclk) begin
        if (sys_rst || !run) begin
            ovf_q <= 1'b0;
            below_cnt_q <= 32'h0;
        end else if (gate_end && over) begin
            ovf_q <= 1'b1;
            below_cnt_q <= 32'h0;
        end else if (ovf_q) begin
            if (below_cnt_q == 32'(OVF_CYCLES - 1)) begin
                ovf_q <= 1'b0;
                below_cnt_q <= 32'h0;
            end else begin
                below_cnt_q <= below_cnt_q + 32'h1;
            end
        end
    end

    // Overheat follows the input level; alert only in the alert variant
    // overheat flag
    wire hot = thermal_voltage_in > VIN_HI && !thermal_open;
    always_ff @(posedge mclk) begin
        if (sys_rst || !run) begin
            hot_q <= 1'b0;
            alert_n <= 1'b1;
        end else begin
            hot_q <= hot;
            alert_n <= !(HOT_ALERT && hot);
        end
    end

    // Status word gathered from flag flops, so each has a single writer
    assign sts_q = fdsm_sts_s'{overheat_flag: hot_q,
        speed_count_overflow: ovf_q};

    // Checks
    sequence s_leave_pdn;
        pdn_prev_q && run;
    endsequence
    AST_SRC_REG: assert property (@(posedge mclk) disable iff (sys_rst)
        (cfg_q.duty_source_select && !kick_q) |->
        drive_duty == code_duty(fan_duty_setting_q))
        else $error("register duty not applied");
    AST_OPEN: assert property (@(posedge mclk) disable iff (sys_rst)
        (!cfg_q.duty_source_select && thermal_open && !kick_q) |->
        drive_duty == code_duty(DUTY_OPEN_CODE))
        else $error("open input duty wrong");
    AST_CLAMP: assert property (@(posedge mclk) disable iff (sys_rst)
        vin_duty >= DUTY_MIN && vin_duty <= DUTY_FULL)
        else $error("analog duty out of span");
    AST_HOT: assert property (@(posedge mclk) disable iff (sys_rst)
        (run && hot) |=> sts_q.overheat_flag)
        else $error("overheat flag missing");
    AST_KICK: assert property (@(posedge mclk) disable iff (sys_rst)
        s_leave_pdn |=> kick_q && drive_duty == DUTY_FULL)
        else $error("no full duty kick");
    AST_PDN: assert property (@(posedge mclk) disable iff (sys_rst)
        !run |=> !fan_drive_out)
        else $error("drive during power down");
    AST_FULL: assert property (@(posedge mclk) disable iff (sys_rst)
        code_duty(4'hF) == DUTY_FULL && code_duty(4'h0) == DUTY_MIN)
        else $error("duty end points wrong");
    AST_OVF: assert property (@(posedge mclk) disable iff (sys_rst)
        (run && gate_end && over) |=> sts_q.speed_count_overflow)
        else $error("overflow not set");
    AST_FINE: assert property (@(posedge mclk) disable iff (sys_rst)
        !cfg_q.fine_rpm_step_select |-> fan_speed_reading[8] == 1'b0)
        else $error("coarse reading too wide");
endmodule

// ---- verif/fdsm_fan_model.sv ----
// Fan model: commutation current pulses seen through the sense comparator.
// Assumes timing in mclk cycles; a half period of zero is a stalled fan.
`timescale 1ns/1ns
module fdsm_fan_model #(
    parameter int TH_MV = 100
) (
    // Clock
    input wire logic mclk,
    // Fan behaviour
    input wire logic [15:0] half_per,
    input wire logic [15:0] peak_mv,
    // Comparator output
    output logic sense_pulse
);
    logic [15:0] cnt = 16'h0000;
    logic cur = 1'b0;
    assign sense_pulse = cur && (peak_mv > TH_MV);
    // Pulse train; a stalled rotor leaves the line low, not at its last level
    always @(posedge mclk) begin
        if (half_per == 16'h0000) begin
            cur <= 1'b0;
            cnt <= 16'h0000;
        end else if (cnt >= half_per - 16'h0001) begin
            cur <= ~cur;
            cnt <= 16'h0000;
        end else begin
            cnt <= cnt + 16'h0001;
        end
    end
endmodule

// ---- verif/test_fan_duty_and_speed_monitor.sv ----
// Bench for the fan duty and speed monitor core with a fan model.
// Assumes shortened start, overflow and gate counts set below.
`timescale 1ns/1ns
module test_fan_duty_and_speed_monitor;
    import fdsm_pkg::*;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] cfg_wdata = 8'h02;
    logic cfg_we = 1'b0;
    logic [3:0] duty_wdata = 4'h0;
    logic duty_we = 1'b0;
    logic [7:0] thermal_voltage_in = 8'h00;
    logic thermal_open = 1'b0;
    logic sense_pulse;
    logic fan_drive_out;
    logic alert_n;
    fdsm_cfg_s cfg_q;
    logic [3:0] fan_duty_setting_q;
    logic [8:0] fan_speed_reading;
    fdsm_sts_s sts_q;
    logic [15:0] half_per = 16'h0000;
    logic [15:0] peak_mv = 16'h012C;
    int error_cnt = 0;
    int checks_done = 0;
    int seed = 32'hec6f4d8b;
    logic [8:0] d;
    logic [8:0] lo;
    logic [8:0] hi;
    logic [3:0] rn;
    logic [7:0] tv;
    always #5 mclk = ~mclk;
    fdsm_top #(.START_CYCLES(200), .OVF_CYCLES(1500), .GATE_CYCLES(1000))
    DUT (.mclk(mclk), .sys_rst(sys_rst), .cfg_wdata(cfg_wdata),
        .cfg_we(cfg_we), .duty_wdata(duty_wdata), .duty_we(duty_we),
        .thermal_voltage_in(thermal_voltage_in),
        .thermal_open(thermal_open), .sense_pulse(sense_pulse),
        .fan_drive_out(fan_drive_out), .alert_n(alert_n), .cfg_q(cfg_q),
        .fan_duty_setting_q(fan_duty_setting_q),
        .fan_speed_reading(fan_speed_reading), .sts_q(sts_q));
    fdsm_fan_model FAN (.mclk(mclk), .half_per(half_per),
        .peak_mv(peak_mv), .sense_pulse(sense_pulse));
    task automatic check(input logic [8:0] seen, input logic [8:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("errors %0d checks %0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // One-cycle write strobe, entered at a rising edge; an idle edge
    // follows so that back-to-back calls never retouch a strobe at once
    task automatic wr(input bit duty, input logic [7:0] v);
        cfg_wdata <= v;
        duty_wdata <= v[3:0];
        cfg_we <= !duty;
        duty_we <= duty;
        @(posedge mclk);
        cfg_we <= 1'b0;
        duty_we <= 1'b0;
        @(posedge mclk);
    endtask
    // High cycles over n clocks after a settle wait
    task automatic meas(input int wt, input int n, output logic [8:0] r);
        repeat (wt) @(posedge mclk);
        r = 9'h000;
        repeat (n) begin
            @(posedge mclk);
            r = r + {8'h00, fan_drive_out};
        end
    endtask
    function automatic logic [8:0] duty_exp(input logic [3:0] c);
        int v;
        v = DUTY_MIN + c * DUTY_STEP_X3 / 3;
        return (v > 256) ? DUTY_FULL : 9'(v);
    endfunction
    // Straight line between the span end points, rounded down
    function automatic logic [8:0] vin_exp(input logic [7:0] v);
        int r;
        r = int'(DUTY_FULL - DUTY_MIN) * (int'(v) - int'(VIN_LO))
            / int'(VIN_HI - VIN_LO);
        return 9'(int'(DUTY_MIN) + r);
    endfunction
    function automatic logic [8:0] spd(input int c, input logic [1:0] pc,
        input bit f);
        int v;
        v = c * SEC_PER_MIN / (1 << pc) / RPM_LSB;
        if (v > 511) v = 511;
        return f ? 9'(v) : 9'(v >> 1);
    endfunction
    // Reading for 100 pulses per gate, one pulse of phase slack either way
    task automatic spd_chk(input logic [1:0] pc, input bit f);
        wr(1'b0, {1'b0, f, 1'b1, 2'b00, pc, 1'b0});
        repeat (2100) @(posedge mclk);
        lo = spd(99, pc, f);
        hi = spd(101, pc, f);
        d = fan_speed_reading;
        check({8'h00, d >= lo && d <= hi}, 9'h001);
    endtask
    // Hang guard
    initial begin
        repeat (100000) @(posedge mclk);
        error_cnt++;
        stop_test();
    end
    initial begin
        repeat (9) @(posedge mclk);
        check({4'h0, cfg_q}, 9'h001);
        check({5'h00, fan_duty_setting_q}, 9'h000);
        check(fan_speed_reading, 9'h000);
        check({5'h00, sts_q, alert_n, fan_drive_out}, 9'h002);
        @(posedge mclk);
        sys_rst <= 1'b0;
        meas(5, 180, d);
        check(d, 9'd180);
        meas(600, 256, d);
        check(d, DUTY_MIN);
        thermal_voltage_in <= VIN_LO;
        meas(600, 256, d);
        check(d, DUTY_MIN);
        tv = 8'h54 + 8'($unsigned($random(seed)) % 48);
        thermal_voltage_in <= tv;
        meas(600, 256, d);
        check({8'h00, d > DUTY_MIN && d < DUTY_FULL}, 9'h001);
        check(d, vin_exp(tv));
        thermal_voltage_in <= VIN_HI;
        meas(600, 256, d);
        check(d, DUTY_FULL);
        check({7'h00, sts_q.overheat_flag, alert_n}, 9'h001);
        thermal_voltage_in <= 8'h90;
        repeat (3) @(posedge mclk);
        check({7'h00, sts_q.overheat_flag, alert_n}, 9'h002);
        thermal_voltage_in <= 8'h60;
        thermal_open <= 1'b1;
        meas(600, 256, d);
        check(d, duty_exp(DUTY_OPEN_CODE));
        check({7'h00, sts_q.overheat_flag, alert_n}, 9'h001);
        wr(1'b0, 8'h22);
        rn = 4'($random(seed));
        for (int i = 0; i < 16; i++) begin
            wr(1'b1, {4'h0, 4'(i) ^ rn});
            meas(600, 256, d);
            check({5'h00, fan_duty_setting_q}, {5'h00, 4'(i) ^ rn});
            check(d, duty_exp(4'(i) ^ rn));
        end
        thermal_open <= 1'b0;
        thermal_voltage_in <= VIN_HI;
        wr(1'b0, 8'h02);
        meas(600, 256, d);
        check(d, DUTY_FULL);
        wr(1'b0, 8'h22);
        half_per <= 16'h0005;
        for (int p = 0; p < 8; p++) begin
            spd_chk(2'(p), p[2]);
        end
        peak_mv <= 16'h0032;
        wr(1'b1, 8'h05);
        meas(2100, 256, d);
        check(fan_speed_reading, 9'h000);
        check(d, duty_exp(4'h5));
        peak_mv <= 16'h012C;
        half_per <= 16'h0002;
        wr(1'b0, 8'h60);
        repeat (2100) @(posedge mclk);
        check(fan_speed_reading, SPD_MAX);
        check({8'h00, sts_q.speed_count_overflow}, 9'h001);
        half_per <= 16'h0005;
        repeat (400) @(posedge mclk);
        check({8'h00, sts_q.speed_count_overflow}, 9'h001);
        repeat (3500) @(posedge mclk);
        check({8'h00, sts_q.speed_count_overflow}, 9'h000);
        wr(1'b0, 8'h61);
        meas(3, 600, d);
        check(d, 9'h000);
        check({7'h00, sts_q}, 9'h000);
        wr(1'b0, 8'h60);
        meas(5, 180, d);
        check(d, 9'd180);
        check({4'h0, cfg_q}, 9'h00C);
        stop_test();
    end
endmodule
